// ===== src/mps_defines.svh
// constants of the motion program sequencer: offsets, fields, ranges, timing
`ifndef MPS_DEFINES_SVH
`define MPS_DEFINES_SVH
// register offsets (byte addresses, one 32-bit word each)
`define MPS_REG_CTRL 8'h00
`define MPS_REG_STATUS 8'h04
`define MPS_REG_PADDR 8'h08
`define MPS_REG_PDATA 8'h0c
`define MPS_REG_PLEN 8'h10
`define MPS_REG_POS 8'h14
`define MPS_REG_TARGET 8'h18
`define MPS_REG_SPEED 8'h1c
`define MPS_REG_ACCEL 8'h20
`define MPS_REG_DECEL 8'h24
`define MPS_REG_SCURVE 8'h28
`define MPS_REG_MAXSPD 8'h2c
`define MPS_REG_POSERR 8'h30
// ctrl fields
`define MPS_CTRL_INC_BIT 0
`define MPS_CTRL_MULT_LSB 4
`define MPS_CTRL_MULT_W 2
`define MPS_CTRL_CLR_BIT 8
`define MPS_CTRL_ALARM_BIT 9
`define MPS_CTRL_RESET 32'h0000_0000
// program store geometry
`define MPS_PROGS 16
`define MPS_STEPS 120
`define MPS_STEP_AW 7
// command word: [31:28] opcode, [27:0] signed operand
`define MPS_OP_LSB 28
`define MPS_ARG_W 28
// operand ranges
`define MPS_POS_MAX 999999
`define MPS_SCURVE_MAX 100
`define MPS_RAMP_MAX 20000
`define MPS_MAXSPD_RESET 32'h0000_1388
// forced-stop warning code, shown as 16'h0ae6 in status
`define MPS_WARN_FORCED 16'h0ae6
// move emulation: one position unit per this many ns of motion
`define MPS_CLK_NS 5
`define MPS_STEP_NS 10
`define MPS_STEP_CYC ((`MPS_STEP_NS + `MPS_CLK_NS - 1) / `MPS_CLK_NS)
`endif

// ===== src/mps_pkg.sv
// types of the motion program sequencer
package mps_pkg;
  typedef enum logic [5:0] {
    MPS_IDLE = 6'b000001,
    MPS_FETCH = 6'b000010,
    MPS_EXEC = 6'b000100,
    MPS_MOVE = 6'b001000,
    MPS_DONE = 6'b010000,
    MPS_STOP = 6'b100000
  } mps_state_type;
  typedef enum logic [3:0] {
    MPS_CMD_END = 4'h0,
    MPS_CMD_SPEED = 4'h1,
    MPS_CMD_SCURVE = 4'h2,
    MPS_CMD_RAMP = 4'h3,
    MPS_CMD_ACCEL = 4'h4,
    MPS_CMD_DECEL = 4'h5,
    MPS_CMD_ABS = 4'h6,
    MPS_CMD_ABSC = 4'h7,
    MPS_CMD_INC = 4'h8
  } mps_cmd_type;
endpackage : mps_pkg

// ===== src/mps_wb_slave.sv
// classic wishbone slave front end: one-cycle ack, pulses for the core
`timescale 1ns/1ps
module mps_wb_slave (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic ack_o,
  // core side
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [31:0] wdata_o
);
  typedef struct packed {
    logic ack;
  } mps_wb_type;
  mps_wb_type s_q;
  mps_wb_type s_d;
  logic req;

  // ack one cycle after request; dropped the next cycle so it never repeats
  assign req = cyc_i & stb_i & ~s_q.ack;
  always_comb begin
    s_d = s_q;
    s_d.ack = req;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign ack_o = s_q.ack;
  // the write takes effect on the acking edge; partial sel is ignored
  assign wr_o = req & we_i & (sel_i == 4'hf);
  assign rd_o = req & ~we_i;
  assign addr_o = adr_i;
  assign wdata_o = dat_i;
endmodule : mps_wb_slave

// ===== src/mps_sequencer.sv
// motion program sequencer: program store, interpreter, stop handling
//
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "mps_defines.svh"
module mps_sequencer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone register bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // discrete inputs from the machine controller
  input wire logic servo_enable_in_i,
  input wire logic forced_stop_in_i,
  input wire logic fwd_limit_in_i,
  input wire logic rev_limit_in_i,
  input wire logic fwd_start_in_i,
  input wire logic auto_manual_select_i,
  input wire logic [3:0] prog_select_i,
  input wire logic alarm_i,
  // drive outputs
  output logic drive_on_o,
  output logic dyn_brake_o,
  output logic servo_lock_o,
  output logic busy_o,
  output logic prog_err_o,
  output logic [15:0] warn_code_o
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    mps_pkg::mps_state_type st;
    logic [31:0] ctrl;
    logic [`MPS_STEP_AW-1:0] paddr;
    logic [`MPS_STEP_AW-1:0] pc;
    logic [`MPS_STEP_AW-1:0] pend;
    logic [31:0] pos;
    logic [31:0] target;
    logic [31:0] speed;
    logic [31:0] accel;
    logic [31:0] decel;
    logic [31:0] scurve;
    logic [31:0] maxspd;
    logic [31:0] poserr;
    logic [3:0] tick;
    logic abs_seen;
    logic err;
    logic start_q;
    logic drive;
    logic brake;
    logic lock;
    logic [15:0] warn;
    logic [31:0] rdata;
  } mps_core_type;
  mps_core_type c_q;
  mps_core_type c_d;

  // program store: one word per step, shared by all sixteen programs
  logic [31:0] prog_mem [0:`MPS_STEPS-1];
  // start and length of each program, in steps
  logic [`MPS_STEP_AW-1:0] prog_base [0:`MPS_PROGS-1];
  logic [`MPS_STEP_AW-1:0] prog_len [0:`MPS_PROGS-1];
  logic [31:0] cur_word;

  logic bus_wr;
  logic bus_rd;
  logic [7:0] bus_addr;
  logic [31:0] bus_wdata;

  // ---------------------------------------------------------------
  // bus front end
  // ---------------------------------------------------------------
  mps_wb_slave u_wb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .dat_i(dat_i),
    .sel_i(sel_i),
    .ack_o(ack_o),
    .wr_o(bus_wr),
    .rd_o(bus_rd),
    .addr_o(bus_addr),
    .wdata_o(bus_wdata)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // signed range check of a 32-bit value against the bounds lo and hi
  function automatic logic in_range(input logic [31:0] v,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
    in_range = ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
  endfunction : in_range

  // operand sign-extended from the command word
  function automatic logic [31:0] operand(input logic [31:0] w);
    operand = {{(32-`MPS_ARG_W){w[`MPS_ARG_W-1]}}, w[`MPS_ARG_W-1:0]};
  endfunction : operand

  logic [31:0] arg;
  logic [31:0] pos_lim;
  logic [31:0] neg_lim;
  logic [31:0] inc_tgt;
  mps_pkg::mps_cmd_type op;
  logic [3:0] prog_no;
  // wide enough for sixteen full-length entries, so the sum cannot wrap
  logic [`MPS_STEP_AW+3:0] total_len;

  assign cur_word = prog_mem[c_q.pc];
  assign op = mps_pkg::mps_cmd_type'(cur_word[31:`MPS_OP_LSB]);
  assign arg = operand(cur_word);
  assign pos_lim = 32'(`MPS_POS_MAX);
  assign neg_lim = 32'(-`MPS_POS_MAX);
  assign inc_tgt = c_q.pos + arg;
  assign prog_no = prog_select_i;

  // program table layout: programs packed back to back in number order
  always_comb begin
    logic [`MPS_STEP_AW+3:0] acc;
    acc = '0;
    for (int i = 0; i < `MPS_PROGS; i++) begin
      prog_base[i] = acc[`MPS_STEP_AW-1:0];
      acc = acc + {4'h0, prog_len[i]};
    end
    total_len = acc;
  end

  // ---------------------------------------------------------------
  // program memory and length table writes
  // ---------------------------------------------------------------
  // store writes only while idle so a running program never changes
  always_ff @(posedge clk_i) begin
    if (bus_wr && bus_addr == `MPS_REG_PDATA &&
        c_q.st == mps_pkg::MPS_IDLE &&
        c_q.paddr < `MPS_STEP_AW'(`MPS_STEPS)) begin
      prog_mem[c_q.paddr] <= bus_wdata;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `MPS_PROGS; i++) begin
        prog_len[i] <= '0;
      end
    end else if (bus_wr && bus_addr == `MPS_REG_PLEN &&
                 c_q.st == mps_pkg::MPS_IDLE) begin
      prog_len[bus_wdata[19:16]] <= bus_wdata[`MPS_STEP_AW-1:0];
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic stop_req;
    logic at_lim;
    logic dir_fwd;
    stop_req = 1'b0;
    at_lim = 1'b0;
    dir_fwd = 1'b0;
    c_d = c_q;
    c_d.start_q = fwd_start_in_i;
    c_d.rdata = 32'h0000_0000;
    dir_fwd = $signed(c_q.target) > $signed(c_q.pos);

    // register writes
    if (bus_wr) begin
      case (bus_addr)
        `MPS_REG_CTRL: c_d.ctrl = bus_wdata; // unit multiplier kept
        `MPS_REG_PADDR: c_d.paddr = bus_wdata[`MPS_STEP_AW-1:0];
        `MPS_REG_PDATA: c_d.paddr = c_q.paddr + `MPS_STEP_AW'(1);
        `MPS_REG_MAXSPD: c_d.maxspd = bus_wdata;
        `MPS_REG_STATUS: c_d.err = 1'b0;
        default: ;
      endcase
    end

    // stop handling, strongest first
    if (alarm_i || c_q.ctrl[`MPS_CTRL_ALARM_BIT]) begin
      c_d.drive = 1'b0;
      c_d.brake = 1'b1;
      c_d.lock = 1'b0;
      c_d.warn = forced_stop_in_i ? 16'h0000 : `MPS_WARN_FORCED;
      stop_req = 1'b1;
    end else if (!forced_stop_in_i) begin
      c_d.drive = 1'b0;
      c_d.brake = 1'b1;
      c_d.lock = 1'b0;
      c_d.warn = `MPS_WARN_FORCED;
      stop_req = 1'b1;
    end else if (!servo_enable_in_i) begin
      c_d.drive = 1'b0;
      c_d.brake = 1'b0; // coast
      c_d.lock = 1'b0;
      c_d.warn = 16'h0000;
      stop_req = 1'b1;
    end else begin
      c_d.drive = 1'b1;
      c_d.brake = 1'b0;
      c_d.lock = 1'b1;
      c_d.warn = 16'h0000;
    end

    // limit only blocks motion toward the open switch
    at_lim = (dir_fwd && !fwd_limit_in_i) ||
             (!dir_fwd && !rev_limit_in_i);
    if (!fwd_limit_in_i || !rev_limit_in_i) begin
      c_d.poserr = 32'h0000_0000;
    end

    case (c_q.st)
      mps_pkg::MPS_IDLE: begin
        if (fwd_start_in_i && !c_q.start_q && !stop_req &&
            auto_manual_select_i && prog_len[prog_no] != '0 &&
            total_len <= (`MPS_STEP_AW+4)'(`MPS_STEPS)) begin
          c_d.pc = prog_base[prog_no];
          c_d.pend = prog_base[prog_no] + prog_len[prog_no];
          c_d.abs_seen = 1'b0;
          c_d.err = 1'b0;
          c_d.st = mps_pkg::MPS_FETCH;
        end
      end
      mps_pkg::MPS_FETCH: begin
        if (c_q.pc == c_q.pend) begin
          c_d.st = mps_pkg::MPS_DONE;
        end else begin
          c_d.st = mps_pkg::MPS_EXEC;
        end
      end
      mps_pkg::MPS_EXEC: begin
        c_d.pc = c_q.pc + `MPS_STEP_AW'(1);
        c_d.st = mps_pkg::MPS_FETCH;
        case (op)
          mps_pkg::MPS_CMD_END: c_d.st = mps_pkg::MPS_DONE;
          mps_pkg::MPS_CMD_SPEED: begin
            if (in_range(arg, 32'h0, c_q.maxspd)) begin
              c_d.speed = arg;
            end else begin
              c_d.err = 1'b1;
            end
          end
          mps_pkg::MPS_CMD_SCURVE: begin
            if (in_range(arg, 32'h0, 32'(`MPS_SCURVE_MAX))) begin
              c_d.scurve = arg;
            end else begin
              c_d.err = 1'b1;
            end
          end
          mps_pkg::MPS_CMD_RAMP, mps_pkg::MPS_CMD_ACCEL,
          mps_pkg::MPS_CMD_DECEL: begin
            // exec never overlaps a move, so ramps stay fixed in motion
            if (in_range(arg, 32'h0, 32'(`MPS_RAMP_MAX))) begin
              if (op != mps_pkg::MPS_CMD_DECEL) begin
                c_d.accel = arg;
              end
              if (op != mps_pkg::MPS_CMD_ACCEL) begin
                c_d.decel = arg;
              end
            end else begin
              c_d.err = 1'b1;
            end
          end
          mps_pkg::MPS_CMD_ABS, mps_pkg::MPS_CMD_ABSC: begin
            // continuous form is refused without an earlier absolute move
            if (!in_range(arg, neg_lim, pos_lim) ||
                (op == mps_pkg::MPS_CMD_ABSC && !c_q.abs_seen)) begin
              c_d.err = 1'b1;
            end else begin
              c_d.target = arg;
              c_d.abs_seen = 1'b1;
              c_d.st = mps_pkg::MPS_MOVE;
            end
          end
          mps_pkg::MPS_CMD_INC: begin
            if (!in_range(arg, neg_lim, pos_lim) ||
                !in_range(inc_tgt, neg_lim, pos_lim)) begin
              c_d.err = 1'b1;
            end else begin
              c_d.target = inc_tgt;
              c_d.st = mps_pkg::MPS_MOVE;
            end
          end
          default: c_d.err = 1'b1;
        endcase
        if (c_d.err) begin
          c_d.st = mps_pkg::MPS_DONE;
        end
      end
      mps_pkg::MPS_MOVE: begin
        // one position unit per two ticks; the unit size in micrometres is
        // ten to the multiplier, which scales no figure held or reported here
        c_d.tick = c_q.tick + 4'h1;
        if (c_q.pos == c_q.target) begin
          c_d.st = mps_pkg::MPS_FETCH;
        end else if (at_lim) begin
          c_d.tick = 4'h0; // hold servo-locked at the limit
        end else if (c_q.tick >= 4'(`MPS_STEP_CYC - 1)) begin
          c_d.tick = 4'h0;
          c_d.pos = dir_fwd ? c_q.pos + 32'h1 : c_q.pos - 32'h1;
          c_d.poserr = c_q.target - c_d.pos;
        end
      end
      mps_pkg::MPS_DONE: c_d.st = mps_pkg::MPS_IDLE;
      mps_pkg::MPS_STOP: begin
        if (!stop_req) begin
          c_d.st = mps_pkg::MPS_IDLE;
        end
      end
      default: c_d.st = mps_pkg::MPS_IDLE;
    endcase

    // any stop or leaving program mode aborts the program
    if ((stop_req || !auto_manual_select_i) &&
        c_q.st != mps_pkg::MPS_IDLE) begin
      c_d.st = mps_pkg::MPS_STOP;
    end

    // register reads
    if (bus_rd) begin
      case (bus_addr)
        `MPS_REG_CTRL: c_d.rdata = c_q.ctrl;
        `MPS_REG_STATUS: c_d.rdata = {c_q.warn, 8'h00, 2'b00, c_q.st};
        `MPS_REG_PADDR: c_d.rdata = 32'(c_q.paddr);
        `MPS_REG_PDATA: c_d.rdata = prog_mem[c_q.paddr];
        `MPS_REG_PLEN: c_d.rdata = 32'(total_len);
        `MPS_REG_POS: c_d.rdata = c_q.pos;
        `MPS_REG_TARGET: c_d.rdata = c_q.target;
        `MPS_REG_SPEED: c_d.rdata = c_q.speed;
        `MPS_REG_ACCEL: c_d.rdata = c_q.accel;
        `MPS_REG_DECEL: c_d.rdata = c_q.decel;
        `MPS_REG_SCURVE: c_d.rdata = c_q.scurve;
        `MPS_REG_MAXSPD: c_d.rdata = c_q.maxspd;
        `MPS_REG_POSERR: c_d.rdata = c_q.poserr;
        default: c_d.rdata = 32'h0000_0000;
      endcase
      if (bus_addr == `MPS_REG_STATUS) begin
        c_d.rdata[8] = c_q.err;
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c_q <= '0;
      c_q.st <= mps_pkg::MPS_IDLE;
      c_q.ctrl <= `MPS_CTRL_RESET; // absolute system by default
      c_q.maxspd <= `MPS_MAXSPD_RESET;
      c_q.start_q <= 1'b1; // a start held through reset does not fire
    end else begin
      c_q <= c_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign dat_o = c_q.rdata;
  assign drive_on_o = c_q.drive;
  assign dyn_brake_o = c_q.brake;
  assign servo_lock_o = c_q.lock;
  assign busy_o = c_q.st != mps_pkg::MPS_IDLE;
  assign prog_err_o = c_q.err;
  assign warn_code_o = c_q.warn;
endmodule : mps_sequencer

// ===== test/mps_sequencer_asserts.sv
// checker: stop handling and program gating of the sequencer
`timescale 1ns/1ps
`include "mps_defines.svh"
module mps_sequencer_asserts (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // inputs of the sequencer
  input wire logic cyc_i,
  input wire logic we_i,
  input wire logic servo_enable_in_i,
  input wire logic forced_stop_in_i,
  input wire logic fwd_limit_in_i,
  input wire logic rev_limit_in_i,
  input wire logic fwd_start_in_i,
  input wire logic auto_manual_select_i,
  input wire logic alarm_i,
  // outputs of the sequencer
  input wire logic drive_on_o,
  input wire logic dyn_brake_o,
  input wire logic servo_lock_o,
  input wire logic busy_o,
  input wire logic prog_err_o,
  input wire logic [15:0] warn_code_o
);
  // ----
  // properties
  // ----
  logic run_ok;
  logic rst_q;
  // outputs leave reset one edge after its release, so wait that edge too
  always_ff @(posedge clk_i) begin
    rst_q <= rst_i;
  end
  // no stop request from the pins is pending
  assign run_ok = servo_enable_in_i && forced_stop_in_i && !alarm_i;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i || rst_q);
  chk_coast_off: assert property (
    !servo_enable_in_i && forced_stop_in_i && !alarm_i
    |=> !drive_on_o && !dyn_brake_o) else $error("no coast on enable off");
  chk_alarm_brake: assert property (
    alarm_i |=> !drive_on_o && dyn_brake_o) else $error("no brake on alarm");
  chk_forced_brake: assert property (
    !forced_stop_in_i |=> !drive_on_o && dyn_brake_o
    && warn_code_o == `MPS_WARN_FORCED) else $error("forced stop wrong");
  chk_warn_clear: assert property (
    forced_stop_in_i |=> warn_code_o == 16'h0000)
    else $error("warning stays without forced stop");
  chk_limit_lock: assert property (
    run_ok && !(fwd_limit_in_i && rev_limit_in_i)
    |=> servo_lock_o && drive_on_o) else $error("limit off not locked");
  chk_drive_up: assert property (
    run_ok |=> drive_on_o) else $error("drive off without a stop");
  chk_auto_gate: assert property (
    !auto_manual_select_i && !busy_o |=> !busy_o)
    else $error("program ran with auto select off");
  chk_err_hold: assert property (
    prog_err_o && !fwd_start_in_i && !(cyc_i && we_i) |=> prog_err_o)
    else $error("program error dropped by itself");
endmodule : mps_sequencer_asserts
bind mps_sequencer mps_sequencer_asserts u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .we_i(we_i),
  .servo_enable_in_i(servo_enable_in_i),
  .forced_stop_in_i(forced_stop_in_i), .fwd_limit_in_i(fwd_limit_in_i),
  .rev_limit_in_i(rev_limit_in_i), .fwd_start_in_i(fwd_start_in_i),
  .auto_manual_select_i(auto_manual_select_i), .alarm_i(alarm_i),
  .drive_on_o(drive_on_o), .dyn_brake_o(dyn_brake_o),
  .servo_lock_o(servo_lock_o), .busy_o(busy_o), .prog_err_o(prog_err_o),
  .warn_code_o(warn_code_o));

// ===== test/mps_ctrl_model.sv
// controller model: drives the discrete inputs of the sequencer
`timescale 1ns/1ps
module mps_ctrl_model (
  // clock
  input wire logic clk_i,
  // discrete levels toward the sequencer
  output logic servo_enable_o,
  output logic forced_stop_o,
  output logic fwd_limit_o,
  output logic rev_limit_o,
  output logic alarm_o,
  output logic auto_select_o,
  output logic fwd_start_o,
  output logic [3:0] prog_select_o
);
  // ----
  // levels and start sequence
  // ----
  // power-up: all permissives on, no start, program 0
  initial begin
    {servo_enable_o, forced_stop_o, fwd_limit_o, rev_limit_o} = 4'hf;
    alarm_o = 1'b0;
    auto_select_o = 1'b1;
    fwd_start_o = 1'b0;
    prog_select_o = 4'h0;
  end
  // all levels move on one edge so no mixed state is ever seen
  task automatic set_levels(input logic [5:0] lv);
    @(posedge clk_i);
    {servo_enable_o, forced_stop_o, fwd_limit_o, rev_limit_o, alarm_o,
      auto_select_o} <= lv;
  endtask : set_levels
  // select settles two edges before start rises; start held three
  task automatic start_prog(input logic [3:0] num);
    @(posedge clk_i);
    prog_select_o <= num;
    repeat (2) @(posedge clk_i);
    fwd_start_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    fwd_start_o <= 1'b0;
  endtask : start_prog
endmodule : mps_ctrl_model

// ===== test/test_motion_program_sequencer.sv
// testbench of the motion program sequencer: bus, pins and programs
`timescale 1ns/1ps
`include "mps_defines.svh"
module test_motion_program_sequencer;
  // ----
  // design, controller model and shared tasks
  // ----
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, busy_o, prog_err_o;
  logic servo_enable_in_i, forced_stop_in_i, fwd_limit_in_i, alarm_i;
  logic rev_limit_in_i, fwd_start_in_i, auto_manual_select_i, saw_busy;
  logic drive_on_o, dyn_brake_o, servo_lock_o;
  logic [3:0] sel_i, prog_select_i;
  logic [7:0] adr_i;
  logic [15:0] warn_code_o;
  logic [31:0] dat_i, dat_o, rd;
  int n_mismatch, n_compared;
  mps_sequencer u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
    .dat_o(dat_o), .ack_o(ack_o), .servo_enable_in_i(servo_enable_in_i),
    .forced_stop_in_i(forced_stop_in_i), .fwd_limit_in_i(fwd_limit_in_i),
    .rev_limit_in_i(rev_limit_in_i), .fwd_start_in_i(fwd_start_in_i),
    .auto_manual_select_i(auto_manual_select_i),
    .prog_select_i(prog_select_i), .alarm_i(alarm_i),
    .drive_on_o(drive_on_o), .dyn_brake_o(dyn_brake_o),
    .servo_lock_o(servo_lock_o), .busy_o(busy_o),
    .prog_err_o(prog_err_o), .warn_code_o(warn_code_o));
  mps_ctrl_model u_ctrl (
    .clk_i(clk_i), .servo_enable_o(servo_enable_in_i),
    .forced_stop_o(forced_stop_in_i), .fwd_limit_o(fwd_limit_in_i),
    .rev_limit_o(rev_limit_in_i), .alarm_o(alarm_i),
    .auto_select_o(auto_manual_select_i), .fwd_start_o(fwd_start_in_i),
    .prog_select_o(prog_select_i));
  // 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // remembers whether a program left idle since the last clear
  always @(posedge clk_i) begin
    if (busy_o === 1'b1) begin
      saw_busy <= 1'b1;
    end
  end
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  // a bound that runs out counts as a mismatch and ends the run
  task automatic timed_out(input string what);
    n_mismatch++;
    $display("[ERR] %s expected done seen timeout", what);
    conclude();
  endtask : timed_out
  // one classic cycle; read data is taken at the ack edge only
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    for (k = 0; k < 50 && ack_o !== 1'b1; k++) @(posedge clk_i);
    if (k == 50) timed_out("ack");
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : wb
  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    check(what, rd, e);
  endtask : rd_chk
  // starts a program from the pins and waits, bounded, for idle
  task automatic run(input logic [3:0] num);
    int k;
    @(posedge clk_i);
    saw_busy <= 1'b0;
    u_ctrl.start_prog(num);
    repeat (2) @(posedge clk_i);
    for (k = 0; k < 3000 && busy_o !== 1'b0; k++) @(posedge clk_i);
    if (k == 3000) timed_out("idle");
  endtask : run
  function automatic logic [31:0] cw(input logic [3:0] op, input int v);
    cw = {op, v[27:0]};
  endfunction : cw
  // lv is {enable, forced, fwd limit, rev limit, alarm, auto}
  task automatic stop_case(input logic [5:0] lv, input logic [1:0] db,
                           input logic [15:0] wc);
    u_ctrl.set_levels(lv);
    repeat (3) @(posedge clk_i);
    check("drive_on", drive_on_o, db[1]);
    check("dyn_brake", dyn_brake_o, db[0]);
    check("warn_code", warn_code_o, wc);
  endtask : stop_case
  // ----
  // scenarios
  // ----
  // programs 0..3 back to back; 2 and 3 carry faulty steps
  task automatic t_load;
    logic [31:0] w [13];
    w = '{cw(mps_pkg::MPS_CMD_SPEED, 100), cw(mps_pkg::MPS_CMD_ACCEL, 200),
      cw(mps_pkg::MPS_CMD_DECEL, 300), cw(mps_pkg::MPS_CMD_ABS, 20),
      cw(mps_pkg::MPS_CMD_END, 0), cw(mps_pkg::MPS_CMD_RAMP, 50),
      cw(mps_pkg::MPS_CMD_SCURVE, 100), cw(mps_pkg::MPS_CMD_INC, -5),
      cw(mps_pkg::MPS_CMD_END, 0), cw(mps_pkg::MPS_CMD_ABS, 1000000),
      cw(mps_pkg::MPS_CMD_END, 0), cw(mps_pkg::MPS_CMD_ABSC, 10),
      cw(mps_pkg::MPS_CMD_END, 0)};
    wb(1'b1, `MPS_REG_PADDR, 32'h0000_0000);
    foreach (w[i]) wb(1'b1, `MPS_REG_PDATA, w[i]);
    wb(1'b1, `MPS_REG_PLEN, {12'h000, 4'h0, 9'h000, 7'h05});
    wb(1'b1, `MPS_REG_PLEN, {12'h000, 4'h1, 9'h000, 7'h04});
    wb(1'b1, `MPS_REG_PLEN, {12'h000, 4'h2, 9'h000, 7'h02});
    wb(1'b1, `MPS_REG_PLEN, {12'h000, 4'h3, 9'h000, 7'h02});
    rd_chk("plen", `MPS_REG_PLEN, 32'h0000_000d);
  endtask : t_load
  task automatic t_stops;
    stop_case(6'b111101, 2'b10, 16'h0000);
    stop_case(6'b011101, 2'b00, 16'h0000);
    stop_case(6'b111111, 2'b01, 16'h0000);
    stop_case(6'b101101, 2'b01, `MPS_WARN_FORCED);
    stop_case(6'b110101, 2'b10, 16'h0000);
    check("servo_lock", servo_lock_o, 1'b1);
    rd_chk("poserr", `MPS_REG_POSERR, 32'h0000_0000);
    u_ctrl.set_levels(6'b111100);
    run(4'h0);
    check("auto_off_busy", saw_busy, 1'b0);
    u_ctrl.set_levels(6'b111101);
  endtask : t_stops
  task automatic t_moves;
    run(4'h0);
    check("busy_seen", saw_busy, 1'b1);
    rd_chk("pos_abs", `MPS_REG_POS, 32'h0000_0014);
    rd_chk("target", `MPS_REG_TARGET, 32'h0000_0014);
    rd_chk("speed", `MPS_REG_SPEED, 32'h0000_0064);
    rd_chk("accel", `MPS_REG_ACCEL, 32'h0000_00c8);
    rd_chk("decel", `MPS_REG_DECEL, 32'h0000_012c);
    // forward limit off: the reverse step of program 1 must still run
    u_ctrl.set_levels(6'b110101);
    run(4'h1);
    rd_chk("pos_inc", `MPS_REG_POS, 32'h0000_000f);
    rd_chk("ramp_acc", `MPS_REG_ACCEL, 32'h0000_0032);
    rd_chk("ramp_dec", `MPS_REG_DECEL, 32'h0000_0032);
    rd_chk("scurve", `MPS_REG_SCURVE, 32'h0000_0064);
    u_ctrl.set_levels(6'b111101);
  endtask : t_moves
  task automatic t_errors;
    run(4'h2);
    check("err_range", prog_err_o, 1'b1);
    rd_chk("pos_kept", `MPS_REG_POS, 32'h0000_000f);
    wb(1'b1, `MPS_REG_STATUS, 32'h0000_0000);
    repeat (2) @(posedge clk_i);
    check("err_clear", prog_err_o, 1'b0);
    run(4'h3);
    check("err_absc", prog_err_o, 1'b1);
    // one more program of 127 steps pushes the total past the store
    wb(1'b1, `MPS_REG_PLEN, {12'h000, 4'hf, 9'h000, 7'h7f});
    run(4'h0);
    check("over_total", saw_busy, 1'b0);
  endtask : t_errors
  // main sequence
  initial begin
    {rst_i, cyc_i, stb_i, we_i, saw_busy} = 5'h10;
    adr_i = 8'h00;
    dat_i = 32'h0000_0000;
    sel_i = 4'hf;
    n_mismatch = 0;
    n_compared = 0;
    repeat (12) @(posedge clk_i);
    check("drive_rst", drive_on_o, 1'b0);
    rst_i <= 1'b0;
    rd_chk("maxspd", `MPS_REG_MAXSPD, `MPS_MAXSPD_RESET);
    rd_chk("ctrl_abs", `MPS_REG_CTRL, `MPS_CTRL_RESET);
    wb(1'b1, `MPS_REG_CTRL, 32'h0000_0020);
    rd_chk("ctrl_mult", `MPS_REG_CTRL, 32'h0000_0020);
    wb(1'b1, `MPS_REG_CTRL, `MPS_CTRL_RESET);
    rd_chk("unmapped", 8'h3c, 32'h0000_0000);
    t_load();
    t_stops();
    t_moves();
    t_errors();
    conclude();
  end
endmodule : test_motion_program_sequencer
